// [core/iso_rx_irq_bank.sv]
// receive-context interrupt event/mask set-clear pairs and bus-management initial values
// assumes completion strobes and serial bus reset arrive from logic on clk_i
//
// Function
// - a completed input command with interrupt bits set raises that context's request line
// - each context event bit is set on the rising edge of its request line, not its level
// - writing ones at the event set address sets those event bits, zeros leave them alone
// - an event bit clears only when software writes one to it at the event clear address
// - a read at the event clear address returns event bits anded with the mask bits
// - event bits 31 to 4 read as zero and cannot be written
// - event bit n marks that context n caused the aggregated receive interrupt
// - each mask bit enables the aggregated interrupt for the event bit at its position
// - ones at mask set set mask bits, ones at mask clear clear them, both read the mask
// - the 13-bit initial bandwidth field is read-write, resets to 1333h, survives bus reset
// - initial bandwidth bits 31 to 13 read as zero
// - on any reset the initial bandwidth field is copied to the bandwidth available csr
// - the 32-bit initial channels-high field is read-write, resets to all ones
// - on any reset the channels-high field is copied to the channels available high csr
//
// Our own choice: the Wishbone slave port.
module iso_rx_irq_bank #(
   parameter int num_ctx = iso_rx_irq_pkg::num_contexts
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               bus_reset_i,
   input  wire logic [num_ctx-1:0] ctx_interrupt_i,
   input  wire logic [31:0]        wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic               wb_we_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   output logic                    aggregated_rx_interrupt_o,
   output logic      [12:0]        bandwidth_available_o,
   output logic      [31:0]        channels_available_high_o,
   output logic                    irq_o
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [num_ctx-1:0] rx_event;
   logic [num_ctx-1:0] rx_mask;
   logic [num_ctx-1:0] ctx_prev;
   logic [12:0]        initial_bandwidth_field;
   logic [31:0]        initial_channels_high_field;
   logic [iso_rx_irq_pkg::status_width-1:0] status;
   logic [iso_rx_irq_pkg::status_width-1:0] status_mask;
   logic               bus_reset_prev;
   logic               access;
   logic               wr;
   logic [7:0]         offset;
   logic [31:0]        wmask;
   logic [31:0]        wdata;
   logic [num_ctx-1:0] ctx_rise;
   logic               bus_reset_rise;
   logic [31:0]        next_rdata;

   // merge byte lanes into a bit mask so partial writes only touch selected bytes
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // request is taken only while ack is low, giving one ack per request
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = access & wb_we_i;
   assign offset = wb_adr_i[7:0];
   assign wmask  = lane_mask(wb_sel_i);
   assign wdata  = wb_dat_i & wmask;

   ////////////////////////////////////////////////////////////////////////////////
   // edge detectors: a request line held high sets its bit only once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctx_prev       <= '0;
         bus_reset_prev <= 1'b0;
      end else begin
         ctx_prev       <= ctx_interrupt_i;
         bus_reset_prev <= bus_reset_i;
      end
   end

   assign ctx_rise       = ctx_interrupt_i & ~ctx_prev;
   assign bus_reset_rise = bus_reset_i & ~bus_reset_prev;

   // event bits: hardware edge or set write sets, clear write clears, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_event <= iso_rx_irq_pkg::event_reset;
      end else begin
         rx_event <= (rx_event
                      & ~((wr && offset == iso_rx_irq_pkg::iso_rx_event_clear)
                          ? wdata[num_ctx-1:0] : '0))
                     | ((wr && offset == iso_rx_irq_pkg::iso_rx_event_set)
                        ? wdata[num_ctx-1:0] : '0)
                     | ctx_rise;
      end
   end

   // mask bits: set pair and clear pair; a simultaneous set and clear cannot occur
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_mask <= iso_rx_irq_pkg::mask_reset;
      end else if (wr && offset == iso_rx_irq_pkg::iso_rx_mask_set) begin
         rx_mask <= rx_mask | wdata[num_ctx-1:0];
      end else if (wr && offset == iso_rx_irq_pkg::iso_rx_mask_clear) begin
         rx_mask <= rx_mask & ~wdata[num_ctx-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // initial value registers: only system/software reset restores them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         initial_bandwidth_field     <= iso_rx_irq_pkg::bandwidth_reset;
         initial_channels_high_field <= iso_rx_irq_pkg::channels_high_reset;
      end else if (wr) begin
         if (offset == iso_rx_irq_pkg::initial_bandwidth) begin
            initial_bandwidth_field <= (initial_bandwidth_field & ~wmask[12:0])
                                       | wdata[12:0];
         end
         if (offset == iso_rx_irq_pkg::initial_channels_high) begin
            initial_channels_high_field <= (initial_channels_high_field & ~wmask)
                                           | wdata;
         end
      end
   end

   // bus-management csr copies: loaded on reset release path and on serial bus reset;
   // during rst_i the copy takes the reset defaults, which equal the fields' reset values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bandwidth_available_o     <= iso_rx_irq_pkg::bandwidth_reset;
         channels_available_high_o <= iso_rx_irq_pkg::channels_high_reset;
      end else if (bus_reset_i) begin
         bandwidth_available_o     <= initial_bandwidth_field;
         channels_available_high_o <= initial_channels_high_field;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // aggregated request toward the top-level event register, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aggregated_rx_interrupt_o <= 1'b0;
      end else begin
         aggregated_rx_interrupt_o <= |(rx_event & rx_mask);
      end
   end

   // block's own sticky status with write-one-to-clear; set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= '0;
      end else begin
         status <= (status & ~((wr && offset == iso_rx_irq_pkg::status_irq)
                               ? wdata[iso_rx_irq_pkg::status_width-1:0] : '0))
                   | {bus_reset_rise, |ctx_rise};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_mask <= '0;
      end else if (wr && offset == iso_rx_irq_pkg::status_irq_mask) begin
         status_mask <= (status_mask & ~wmask[iso_rx_irq_pkg::status_width-1:0])
                        | wdata[iso_rx_irq_pkg::status_width-1:0];
      end
   end

   // level interrupt; lags the status bit by one cycle to stay a flip-flop output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & status_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero and still ack
   always_comb begin
      next_rdata = 32'h00000000;
      unique case (offset)
         iso_rx_irq_pkg::iso_rx_event_set:      next_rdata[num_ctx-1:0] = rx_event;
         iso_rx_irq_pkg::iso_rx_event_clear:
            next_rdata[num_ctx-1:0] = rx_event & rx_mask;
         iso_rx_irq_pkg::iso_rx_mask_set:       next_rdata[num_ctx-1:0] = rx_mask;
         iso_rx_irq_pkg::iso_rx_mask_clear:     next_rdata[num_ctx-1:0] = rx_mask;
         iso_rx_irq_pkg::initial_bandwidth:     next_rdata[12:0] = initial_bandwidth_field;
         iso_rx_irq_pkg::initial_channels_high: next_rdata = initial_channels_high_field;
         iso_rx_irq_pkg::status_irq:
            next_rdata[iso_rx_irq_pkg::status_width-1:0] = status;
         iso_rx_irq_pkg::status_irq_mask:
            next_rdata[iso_rx_irq_pkg::status_width-1:0] = status_mask;
         default:                               next_rdata = 32'h00000000;
      endcase
   end

   // one-cycle ack a cycle after the request is seen; reads never change state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? next_rdata : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   // most antecedents are one bus access or one edge, so each check stays local
   // to the logic it guards and fails on the cycle after the cause; a_idle_data fails in the same cycle

   // context edge sets its bit
   a_event_edge_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctx_interrupt_i[0] && !ctx_prev[0]) |=> rx_event[0])
      else $error("context 0 edge did not set event");

   // a held level never sets again
   a_event_level_only: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctx_interrupt_i[1] && ctx_prev[1] && !rx_event[1] && !wr) |=> !rx_event[1])
      else $error("held level set event again");

   // set write sets
   a_event_set_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_event_set && wdata[2]) |=> rx_event[2])
      else $error("event set write ignored");

   // only a clear write drops a bit
   a_event_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_event[3] && !(wr && offset == iso_rx_irq_pkg::iso_rx_event_clear && wdata[3]))
      |=> rx_event[3])
      else $error("event cleared without clear write");

   // clear write clears when no edge competes
   a_event_clear_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_event_clear && wdata[0]
       && !ctx_rise[0]) |=> !rx_event[0])
      else $error("clear write did not clear");

   // clear address reads the masked events
   a_clear_read_and: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::iso_rx_event_clear)
      |=> wb_ack_o && wb_dat_o == {{(32-num_ctx){1'b0}}, $past(rx_event & rx_mask)})
      else $error("clear address read wrong");

   // mask clear clears
   a_mask_pair: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_mask_clear && wdata[1]) |=> !rx_mask[1])
      else $error("mask clear failed");

   // reserved bandwidth bits stay zero
   a_bw_readback: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::initial_bandwidth)
      |=> wb_dat_o[31:13] == 19'h00000)
      else $error("bandwidth upper bits not zero");

   // serial bus reset copies both fields
   a_bus_reset_copy: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_reset_i |=> bandwidth_available_o == $past(initial_bandwidth_field)
                      && channels_available_high_o == $past(initial_channels_high_field))
      else $error("bus reset copy missing");

   // serial bus reset leaves the init fields alone
   a_bw_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_reset_i && !wr) |=> $stable(initial_bandwidth_field)
                               && $stable(initial_channels_high_field))
      else $error("init field changed on bus reset");

   // registered aggregate follows the masked events
   a_aggregate_out: assert property (@(posedge clk_i) disable iff (rst_i)
      aggregated_rx_interrupt_o == $past(|(rx_event & rx_mask)))
      else $error("aggregated interrupt wrong");

   // the other contexts' edges
   a_edge_ctx1: assert property (@(posedge clk_i) disable iff (rst_i)
      ctx_rise[1] |=> rx_event[1])
      else $error("context 1 edge did not set event");

   a_edge_ctx2: assert property (@(posedge clk_i) disable iff (rst_i)
      ctx_rise[2] |=> rx_event[2])
      else $error("context 2 edge did not set event");

   a_edge_ctx3: assert property (@(posedge clk_i) disable iff (rst_i)
      ctx_rise[3] |=> rx_event[3])
      else $error("context 3 edge did not set event");

   // every written one lands on a set write
   a_set_all_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_event_set)
      |=> (rx_event & $past(wdata[num_ctx-1:0])) == $past(wdata[num_ctx-1:0]))
      else $error("set write missed a bit");

   // a set write never drops a bit
   a_set_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_event_set)
      |=> (rx_event & $past(rx_event)) == $past(rx_event))
      else $error("set write dropped a bit");

   // reading never clears
   a_read_no_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i) |=> (rx_event & $past(rx_event)) == $past(rx_event))
      else $error("read cleared an event");

   // zeros at the clear address keep their bits
   a_clear_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_event_clear)
      |=> (rx_event & $past(rx_event) & ~$past(wdata[num_ctx-1:0]))
          == ($past(rx_event) & ~$past(wdata[num_ctx-1:0])))
      else $error("clear write dropped an unwritten bit");

   // an edge beats a clear in the same cycle
   a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_event_clear && ctx_rise[1]) |=> rx_event[1])
      else $error("clear beat a context edge");

   // set address reads the raw events
   a_set_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::iso_rx_event_set)
      |=> wb_dat_o == {{(32-num_ctx){1'b0}}, $past(rx_event)})
      else $error("event set read wrong");

   // both mask addresses read the mask
   a_mask_set_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::iso_rx_mask_set)
      |=> wb_dat_o == {{(32-num_ctx){1'b0}}, $past(rx_mask)})
      else $error("mask set read wrong");

   a_mask_clr_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::iso_rx_mask_clear)
      |=> wb_dat_o == {{(32-num_ctx){1'b0}}, $past(rx_mask)})
      else $error("mask clear read wrong");

   // mask set sets every written one
   a_mask_set_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_mask_set)
      |=> (rx_mask & $past(wdata[num_ctx-1:0])) == $past(wdata[num_ctx-1:0]))
      else $error("mask set missed a bit");

   // mask clear clears every written one
   a_mask_clr_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && offset == iso_rx_irq_pkg::iso_rx_mask_clear)
      |=> (rx_mask & $past(wdata[num_ctx-1:0])) == {num_ctx{1'b0}})
      else $error("mask clear missed a bit");

   // init field readback
   a_bw_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::initial_bandwidth)
      |=> wb_dat_o[12:0] == $past(initial_bandwidth_field))
      else $error("bandwidth read wrong");

   a_chan_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && offset == iso_rx_irq_pkg::initial_channels_high)
      |=> wb_dat_o == $past(initial_channels_high_field))
      else $error("channels high read wrong");

   // csr copies move only on a serial bus reset
   a_csr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !bus_reset_i |=> $stable(bandwidth_available_o) && $stable(channels_available_high_o))
      else $error("csr copy moved without bus reset");

   // one ack per request, data zero when idle
   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      access |=> wb_ack_o)
      else $error("request not acked");

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   a_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data without ack");

   // an all-zero mask keeps the aggregate low; an enabled context 2 event raises it
   a_agg_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_mask == {num_ctx{1'b0}}) |=> !aggregated_rx_interrupt_o)
      else $error("aggregate high with mask off");

   a_agg_from_ctx: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_event[2] && rx_mask[2]) |=> aggregated_rx_interrupt_o)
      else $error("context 2 did not raise aggregate");

   // own status bits
   a_status_ctx: assert property (@(posedge clk_i) disable iff (rst_i)
      (|ctx_rise) |=> status[iso_rx_irq_pkg::status_ctx_bit])
      else $error("status context bit not set");

   a_status_bus: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_reset_rise |=> status[iso_rx_irq_pkg::status_bus_reset_bit])
      else $error("status bus reset bit not set");

   // main scenarios
   c_edge_to_irq: cover property (@(posedge clk_i) disable iff (rst_i)
      ctx_rise[0] && rx_mask[0] ##2 aggregated_rx_interrupt_o);
   c_set_and_clear: cover property (@(posedge clk_i) disable iff (rst_i)
      ctx_rise[1] && wr && offset == iso_rx_irq_pkg::iso_rx_event_clear && wdata[1]);
   c_bus_reset: cover property (@(posedge clk_i) disable iff (rst_i) bus_reset_rise);
   c_masked_read: cover property (@(posedge clk_i) disable iff (rst_i)
      access && !wb_we_i && offset == iso_rx_irq_pkg::iso_rx_event_clear && |(rx_event & rx_mask));
   c_status_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule

// [core/iso_rx_irq_pkg.sv]
// package for the receive-context interrupt and bus-management init bank
// assumes a 32-bit classic wishbone slave port with byte addresses
package iso_rx_irq_pkg;
   localparam int          num_contexts          = 4;
   localparam logic [7:0]  iso_rx_event_set      = 8'ha0;
   localparam logic [7:0]  iso_rx_event_clear    = 8'ha4;
   localparam logic [7:0]  iso_rx_mask_set       = 8'ha8;
   localparam logic [7:0]  iso_rx_mask_clear     = 8'hac;
   localparam logic [7:0]  initial_bandwidth     = 8'hb0;
   localparam logic [7:0]  initial_channels_high = 8'hb4;
   localparam logic [7:0]  status_irq            = 8'hc0;
   localparam logic [7:0]  status_irq_mask       = 8'hc4;
   localparam int          bandwidth_width       = 13;
   localparam logic [12:0] bandwidth_reset       = 13'h1333;
   localparam logic [31:0] channels_high_reset   = 32'hffffffff;
   localparam logic [3:0]  event_reset           = 4'h0;
   localparam logic [3:0]  mask_reset            = 4'h0;
   // status register layout: bit 0 = a context completion event, bit 1 = serial bus reset seen
   localparam int          status_width          = 2;
   localparam int          status_ctx_bit        = 0;
   localparam int          status_bus_reset_bit  = 1;
endpackage

// [verification/tb_iso_rx_irq_and_bus_mgmt_init.sv]
// self-checking bench for the receive-context interrupt bank and init fields
// assumes a one-cycle registered ack and a one-cycle lag on both interrupt outputs
module tb_iso_rx_irq_and_bus_mgmt_init;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, bus_reset_i, wb_we_i, wb_cyc_i, wb_stb_i;
   logic [3:0]  ctx_interrupt_i, wb_sel_i;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, channels_available_high_o, rd;
   logic        wb_ack_o, aggregated_rx_interrupt_o, irq_o;
   logic [12:0] bandwidth_available_o;
   int          n_fail, n_compared;
   localparam logic [31:0] bw_default = {19'h0, iso_rx_irq_pkg::bandwidth_reset};

   iso_rx_irq_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_reset_i(bus_reset_i),
      .ctx_interrupt_i(ctx_interrupt_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .aggregated_rx_interrupt_o(aggregated_rx_interrupt_o),
      .bandwidth_available_o(bandwidth_available_o),
      .channels_available_high_o(channels_available_high_o), .irq_o(irq_o));

   ////////////////////////////////////////////////////////////////////////////////
   // 40 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counts, verdict and end of run, also reached by a bus timeout
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // word compare; one-bit results are widened so both share one report format
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // classic cycle: hold everything until ack is sampled high, then release
   task automatic bus(input logic we, input logic [7:0] o, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {24'h0, o};
      wb_dat_i <= d;
      wb_sel_i <= s;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 16);
      if (wb_ack_o !== 1'b1) begin
         n_fail++;
         $display("ERROR at %0t got %h expected %h", $time, wb_ack_o, 1'b1);
         wrap_up;
      end else begin
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i  <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      bus(1'b1, o, d, 4'hf, rd);
   endtask

   task automatic rd_chk(input logic [7:0] o, input logic [31:0] exp);
      bus(1'b0, o, 32'h0, 4'hf, rd);
      chk(rd, exp);
   endtask

   // lets registered outputs catch up, then samples clear of the edge
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      n_fail = 0;
      n_compared = 0;
      rst_i = 1'b1;
      bus_reset_i = 1'b0;
      ctx_interrupt_i = 4'h0;
      wb_adr_i = 32'h0;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'hf;
      wb_we_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(iso_rx_irq_pkg::initial_bandwidth, bw_default);
      rd_chk(iso_rx_irq_pkg::initial_channels_high, iso_rx_irq_pkg::channels_high_reset);
      chk({19'h0, bandwidth_available_o}, bw_default);
      chk(channels_available_high_o, iso_rx_irq_pkg::channels_high_reset);
      $display("test reset values done");
      // upper bits are reserved, byte lanes limit the write
      wr(iso_rx_irq_pkg::initial_bandwidth, 32'hffffffff);
      rd_chk(iso_rx_irq_pkg::initial_bandwidth, 32'h00001fff);
      wr(iso_rx_irq_pkg::initial_bandwidth, 32'h00000abc);
      bus(1'b1, iso_rx_irq_pkg::initial_channels_high, 32'h0, 4'h3, rd);
      rd_chk(iso_rx_irq_pkg::initial_channels_high, 32'hffff0000);
      chk({19'h0, bandwidth_available_o}, bw_default);
      @(posedge clk_i);
      bus_reset_i <= 1'b1;
      @(posedge clk_i);
      bus_reset_i <= 1'b0;
      settle;
      chk({19'h0, bandwidth_available_o}, 32'h00000abc);
      chk(channels_available_high_o, 32'hffff0000);
      rd_chk(iso_rx_irq_pkg::initial_bandwidth, 32'h00000abc);
      rd_chk(iso_rx_irq_pkg::initial_channels_high, 32'hffff0000);
      $display("test init fields done");
      // a held request line must not re-set a cleared bit
      @(posedge clk_i);
      ctx_interrupt_i <= 4'h2;
      settle;
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'h2);
      wr(iso_rx_irq_pkg::iso_rx_event_clear, 32'h2);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'h0);
      @(posedge clk_i);
      ctx_interrupt_i <= 4'h8;
      settle;
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'h8);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'h8);
      chk_bit(aggregated_rx_interrupt_o, 1'b0);
      $display("test event edges done");
      // set writes, masked reads and the aggregated line
      wr(iso_rx_irq_pkg::iso_rx_event_set, 32'hffffffff);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'hf);
      wr(iso_rx_irq_pkg::iso_rx_event_set, 32'h0);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'hf);
      wr(iso_rx_irq_pkg::iso_rx_mask_set, 32'h5);
      rd_chk(iso_rx_irq_pkg::iso_rx_mask_set, 32'h5);
      rd_chk(iso_rx_irq_pkg::iso_rx_mask_clear, 32'h5);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_clear, 32'h5);
      settle;
      chk_bit(aggregated_rx_interrupt_o, 1'b1);
      wr(iso_rx_irq_pkg::iso_rx_event_clear, 32'h5);
      settle;
      chk_bit(aggregated_rx_interrupt_o, 1'b0);
      wr(iso_rx_irq_pkg::iso_rx_mask_set, 32'h2);
      settle;
      chk_bit(aggregated_rx_interrupt_o, 1'b1);
      wr(iso_rx_irq_pkg::iso_rx_mask_clear, 32'h7);
      rd_chk(iso_rx_irq_pkg::iso_rx_mask_set, 32'h0);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'ha);
      $display("test mask pairs done");
      // status: context edges and the bus reset are both pending by now
      rd_chk(iso_rx_irq_pkg::status_irq, 32'h3);
      chk_bit(irq_o, 1'b0);
      wr(iso_rx_irq_pkg::status_irq_mask, 32'h1);
      settle;
      chk_bit(irq_o, 1'b1);
      wr(iso_rx_irq_pkg::status_irq, 32'h3);
      rd_chk(iso_rx_irq_pkg::status_irq, 32'h0);
      settle;
      chk_bit(irq_o, 1'b0);
      wr(8'h50, 32'hffffffff);
      rd_chk(8'h50, 32'h0);
      $display("test status and unmapped done");
      // system reset in mid-run reloads the defaults
      @(posedge clk_i);
      ctx_interrupt_i <= 4'h0;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(iso_rx_irq_pkg::initial_bandwidth, bw_default);
      rd_chk(iso_rx_irq_pkg::initial_channels_high, iso_rx_irq_pkg::channels_high_reset);
      chk({19'h0, bandwidth_available_o}, bw_default);
      chk(channels_available_high_o, iso_rx_irq_pkg::channels_high_reset);
      rd_chk(iso_rx_irq_pkg::iso_rx_event_set, 32'h0);
      rd_chk(iso_rx_irq_pkg::iso_rx_mask_set, 32'h0);
      $display("test second reset done");
      wrap_up;
   end
endmodule
